// >>> common/pur_pkg.sv
// shared constants for the power-up reset and lock block
package pur_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_MHZ  = 200;
	localparam int RST_DELAY_NS  = 1000;
	localparam int NS_PER_US     = 1000;
	// least time, so round up to whole cycles
	localparam int RST_DELAY_CYC = (RST_DELAY_NS * CLK_FREQ_MHZ + NS_PER_US - 1) / NS_PER_US;

	// ----------------------------------------------------------------
	// widths and defaults
	// ----------------------------------------------------------------
	localparam int NUM_OUT_DEF = 8;
	localparam int SIG_W       = 16;

	localparam logic [SIG_W-1:0] SIG_RESET  = 16'h0000;
	localparam logic             HYST_SMALL = 1'h0;
	localparam logic             HYST_LARGE = 1'h1;
	localparam logic             LOCK_RESET = 1'h0;

	// ----------------------------------------------------------------
	// readback selection
	// ----------------------------------------------------------------
	localparam logic RD_SEL_PATTERN = 1'h0;
	localparam logic RD_SEL_SIG     = 1'h1;
endpackage

// >>> design/pur_sync.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module pur_sync (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;

	// ----------------------------------------------------------------
	// meta stage is read only by the second stage
	// ----------------------------------------------------------------
	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_reg <= 1'h0;
			sync_reg <= 1'h0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign o_sync = sync_reg;
endmodule
`default_nettype wire

// >>> design/pur_powerup_lock.sv
// power-up reset sequencer with output polarity, hysteresis choice and readback lock
`timescale 1ns/1ps
`default_nettype none
// How it works
// - supply good plus delay releases register reset
// - outputs show reset value through buffer polarity
// - small or large hysteresis chosen by configuration
// - lock bit refuses configuration pattern readback
// - user signature stays readable when locked
module pur_powerup_lock #(
	parameter int NUM_OUT       = pur_pkg::NUM_OUT_DEF,
	parameter int RST_DELAY_CYC = pur_pkg::RST_DELAY_CYC
) (
	input  wire logic                       I_REF_CLK,
	input  wire logic                       I_RST,
	input  wire logic                       I_VCC_ABOVE_RST,
	input  wire logic                       I_VCC_ABOVE_LOW,
	input  wire logic                       I_CFG_WR,
	input  wire logic                       I_CFG_HYST_LARGE,
	input  wire logic [NUM_OUT-1:0]         I_CFG_POLARITY,
	input  wire logic [pur_pkg::SIG_W-1:0]  I_CFG_SIG,
	input  wire logic                       I_CFG_LOCK,
	input  wire logic                       I_USER_LD,
	input  wire logic [NUM_OUT-1:0]         I_USER_D,
	input  wire logic                       I_RD_REQ,
	input  wire logic                       I_RD_SEL,
	output logic                            O_PUR_ACTIVE,
	output logic [NUM_OUT-1:0]              O_OUT,
	output logic                            O_RD_VALID,
	output logic [pur_pkg::SIG_W-1:0]       O_RD_DATA,
	output logic                            O_RD_DENIED,
	output logic                            O_HYST_LARGE,
	output logic                            O_LOCKED
);
	localparam int CNT_W = $clog2(RST_DELAY_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RST_DELAY_CYC - 1);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// pattern word packs polarity plus hysteresis into one signature-wide word
	if (NUM_OUT < 1 || NUM_OUT > pur_pkg::SIG_W - 1) begin : g_bad_num_out
		$error("NUM_OUT out of range");
	end
	if (RST_DELAY_CYC < 1) begin : g_bad_delay
		$error("RST_DELAY_CYC must be at least one");
	end

	typedef enum logic [1:0] {
		ST_OFF,
		ST_DELAY,
		ST_RUN
	} pur_state_t;

	// ----------------------------------------------------------------
	// supply comparator inputs
	// ----------------------------------------------------------------
	logic above_rst_s;
	logic above_low_s;

	pur_sync u_sync_rst (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_RST),
		.i_async (I_VCC_ABOVE_RST),
		.o_sync  (above_rst_s)
	);

	pur_sync u_sync_low (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_RST),
		.i_async (I_VCC_ABOVE_LOW),
		.o_sync  (above_low_s)
	);

	// ----------------------------------------------------------------
	// nonvolatile configuration store
	// ----------------------------------------------------------------
	// only I_RST (an erased part) clears these; the power-up reset never does
	logic                      hyst_reg;
	logic                      hyst_next;
	logic [NUM_OUT-1:0]        pol_reg;
	logic [NUM_OUT-1:0]        pol_next;
	logic [pur_pkg::SIG_W-1:0] sig_reg;
	logic [pur_pkg::SIG_W-1:0] sig_next;
	logic                      lock_reg;
	logic                      lock_next;

	always_comb begin
		hyst_next = hyst_reg;
		pol_next  = pol_reg;
		sig_next  = sig_reg;
		lock_next = lock_reg;
		// a locked part takes no more writes; lock itself is sticky
		if (I_CFG_WR && !lock_reg) begin
			hyst_next = I_CFG_HYST_LARGE;
			pol_next  = I_CFG_POLARITY;
			sig_next  = I_CFG_SIG;
			lock_next = I_CFG_LOCK;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			hyst_reg <= pur_pkg::HYST_SMALL;
			pol_reg  <= '0;
			sig_reg  <= pur_pkg::SIG_RESET;
			lock_reg <= pur_pkg::LOCK_RESET;
		end else begin
			hyst_reg <= hyst_next;
			pol_reg  <= pol_next;
			sig_reg  <= sig_next;
			lock_reg <= lock_next;
		end
	end

	// ----------------------------------------------------------------
	// power-up reset sequencer
	// ----------------------------------------------------------------
	pur_state_t       state_reg;
	pur_state_t       state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             supply_fail;
	logic             pur_next;

	// large hysteresis drops out only below the lower comparator
	always_comb begin
		supply_fail = (hyst_reg == pur_pkg::HYST_LARGE) ? !above_low_s : !above_rst_s;
	end

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			ST_OFF: begin
				cnt_next = '0;
				if (above_rst_s) begin
					state_next = ST_DELAY;
				end
			end
			ST_DELAY: begin
				// delay assumes the system keeps the clock running meanwhile
				if (!above_rst_s) begin
					state_next = ST_OFF;
					cnt_next   = '0;
				end else if (cnt_reg == CNT_LAST) begin
					state_next = ST_RUN;
					cnt_next   = '0;
				end else begin
					cnt_next = cnt_reg + CNT_W'(1);
				end
			end
			ST_RUN: begin
				if (supply_fail) begin
					state_next = ST_OFF;
				end
			end
		endcase
		pur_next = (state_next != ST_RUN);
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			state_reg    <= ST_OFF;
			cnt_reg      <= '0;
			O_PUR_ACTIVE <= 1'h1;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			O_PUR_ACTIVE <= pur_next;
		end
	end

	// ----------------------------------------------------------------
	// user registers and output buffers
	// ----------------------------------------------------------------
	logic [NUM_OUT-1:0] user_reg;
	logic [NUM_OUT-1:0] user_next;
	logic [NUM_OUT-1:0] out_next;

	always_comb begin
		user_next = user_reg;
		if (pur_next) begin
			user_next = '0;
		end else if (I_USER_LD && state_reg == ST_RUN) begin
			// loads before release are not taken; setup is the system's job
			user_next = I_USER_D;
		end
		out_next = user_next ^ pol_next;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			user_reg <= '0;
			O_OUT    <= '0;
		end else begin
			user_reg <= user_next;
			O_OUT    <= out_next;
		end
	end

	// ----------------------------------------------------------------
	// readback port
	// ----------------------------------------------------------------
	logic [pur_pkg::SIG_W-1:0] pattern_word;
	logic                      rd_valid_next;
	logic [pur_pkg::SIG_W-1:0] rd_data_next;
	logic                      rd_denied_next;

	always_comb begin
		pattern_word                = '0;
		pattern_word[NUM_OUT-1:0]   = pol_reg;
		pattern_word[NUM_OUT]       = hyst_reg;
		rd_valid_next               = I_RD_REQ;
		rd_data_next                = '0;
		rd_denied_next              = 1'h0;
		if (I_RD_REQ) begin
			if (I_RD_SEL == pur_pkg::RD_SEL_SIG) begin
				rd_data_next = sig_reg;
			end else if (lock_reg) begin
				rd_denied_next = 1'h1;
			end else begin
				rd_data_next = pattern_word;
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			O_RD_VALID   <= 1'h0;
			O_RD_DATA    <= '0;
			O_RD_DENIED  <= 1'h0;
			O_HYST_LARGE <= pur_pkg::HYST_SMALL;
			O_LOCKED     <= pur_pkg::LOCK_RESET;
		end else begin
			O_RD_VALID   <= rd_valid_next;
			O_RD_DATA    <= rd_data_next;
			O_RD_DENIED  <= rd_denied_next;
			O_HYST_LARGE <= hyst_next;
			O_LOCKED     <= lock_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_RELEASE_AFTER_DELAY: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		$fell(O_PUR_ACTIVE) |-> ($past(state_reg) == ST_DELAY && $past(cnt_reg) == CNT_LAST))
		else $error("reset released without full delay");

	AST_FAIL_RESETS: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(state_reg == ST_RUN && supply_fail) |=> (O_PUR_ACTIVE && user_reg == '0))
		else $error("supply fail did not reset registers");

	AST_OUT_POLARITY: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		O_PUR_ACTIVE |-> (O_OUT == pol_reg))
		else $error("output in reset not set by polarity");

	AST_HYST_SMALL: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(state_reg == ST_RUN && !hyst_reg && !above_rst_s) |=> O_PUR_ACTIVE)
		else $error("small hysteresis did not drop out");

	AST_HYST_LARGE: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(state_reg == ST_RUN && hyst_reg && above_low_s) |=> !O_PUR_ACTIVE)
		else $error("large hysteresis dropped out early");

	AST_LOCK_DENY: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(I_RD_REQ && I_RD_SEL == pur_pkg::RD_SEL_PATTERN && lock_reg) |=> (O_RD_DENIED && O_RD_DATA == '0))
		else $error("locked pattern readback not refused");

	AST_SIG_OPEN: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(I_RD_REQ && I_RD_SEL == pur_pkg::RD_SEL_SIG) |=> (O_RD_VALID && !O_RD_DENIED && O_RD_DATA == $past(sig_reg)))
		else $error("signature readback wrong");

	AST_CFG_KEEP: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(!I_CFG_WR || lock_reg) |=> ($stable(hyst_reg) && $stable(lock_reg) && $stable(sig_reg) && $stable(pol_reg)))
		else $error("configuration changed without a write");
endmodule
`default_nettype wire

// >>> verification/pur_supply_model.sv
// supply comparator model for the power-up reset bench
`timescale 1ns/1ps
`default_nettype none
module pur_supply_model (
	input  wire logic [1:0] i_level,
	output logic            o_above_rst,
	output logic            o_above_low
);
	// ----------------------------------------------------------------
	// comparators
	// ----------------------------------------------------------------
	// level 0 off, 1 between thresholds, 2 fully up; steps only, so no glitching edges
	assign o_above_rst = (i_level == 2'h2);
	assign o_above_low = (i_level != 2'h0);
endmodule
`default_nettype wire

// >>> verification/pur_powerup_lock_tb_top.sv
// testbench for the power-up reset and lock block
`timescale 1ns/1ps
`default_nettype none
module pur_powerup_lock_tb_top;
	localparam int DLY = 4;
	logic        clk, rst, wr, hl, lk, ld, rq, sel;
	logic [1:0]  lvl;
	logic [7:0]  pol, d;
	logic [15:0] sig, v;
	logic        dn;
	int          err_count, cmp_count, n;
	wire logic   va_rst, va_low, act, vld, den, hyo, lko;
	wire logic [7:0]  q;
	wire logic [15:0] rd;

	// ----------------------------------------------------------------
	// harness
	// ----------------------------------------------------------------
	pur_supply_model sup (.i_level(lvl), .o_above_rst(va_rst), .o_above_low(va_low));
	pur_powerup_lock #(.NUM_OUT(8), .RST_DELAY_CYC(DLY)) uut (
		.I_REF_CLK(clk), .I_RST(rst), .I_VCC_ABOVE_RST(va_rst), .I_VCC_ABOVE_LOW(va_low),
		.I_CFG_WR(wr), .I_CFG_HYST_LARGE(hl), .I_CFG_POLARITY(pol), .I_CFG_SIG(sig),
		.I_CFG_LOCK(lk), .I_USER_LD(ld), .I_USER_D(d), .I_RD_REQ(rq), .I_RD_SEL(sel),
		.O_PUR_ACTIVE(act), .O_OUT(q), .O_RD_VALID(vld), .O_RD_DATA(rd),
		.O_RD_DENIED(den), .O_HYST_LARGE(hyo), .O_LOCKED(lko));

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wait_act(input logic lv, input logic [1:0] sl);
		@(negedge clk) lvl = sl;
		n = 0;
		while (act !== lv && n < 40) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic cfg(input logic h, input logic [7:0] p, input logic k);
		@(negedge clk) begin
			wr = 1'h1; hl = h; pol = p; lk = k;
		end
		@(negedge clk) wr = 1'h0;
	endtask

	task automatic rd_op(input logic s);
		@(negedge clk) begin
			rq = 1'h1; sel = s;
		end
		@(negedge clk) rq = 1'h0;
		v = rd;
		dn = den;
		chk("rd_valid", 16'h0001, {15'h0000, vld});
		// the answer stands for one cycle only
		@(negedge clk);
		chk("rd_valid_end", 16'h0000, {15'h0000, vld});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_power(input logic [7:0] p);
		// no user load pulse while the delay runs
		wait_act(1'h0, 2'h2);
		chk("pur_delay", 16'h0001, {15'h0000, (n >= DLY + 2 && n <= DLY + 4)});
		chk("out_polarity", {8'h00, p}, {8'h00, q});
		$display("power-up done");
	endtask

	task automatic t_load_fail;
		@(negedge clk) begin
			ld = 1'h1; d = 8'h0F;
		end
		@(negedge clk) ld = 1'h0;
		chk("out_load", 16'h00AA, {8'h00, q});
		wait_act(1'h1, 2'h1);
		chk("small_fail", 16'h0001, {15'h0000, (n >= 2 && n <= 4)});
		chk("out_reinit", 16'h00A5, {8'h00, q});
		// a load while the supply is down must not reach the registers
		@(negedge clk) begin
			ld = 1'h1; d = 8'h0F;
		end
		@(negedge clk) ld = 1'h0;
		chk("load_refused", 16'h00A5, {8'h00, q});
		$display("small hysteresis done");
	endtask

	task automatic t_large;
		cfg(1'h1, 8'hA5, 1'h0);
		chk("hyst_large", 16'h0001, {15'h0000, hyo});
		wait_act(1'h1, 2'h1);
		chk("large_hold", 16'h0000, {15'h0000, act});
		wait_act(1'h1, 2'h0);
		chk("large_fail", 16'h0001, {15'h0000, (n >= 2 && n <= 4)});
		chk("hyst_kept", 16'h0001, {15'h0000, hyo});
		t_power(8'hA5);
		$display("large hysteresis done");
	endtask

	task automatic t_lock;
		rd_op(1'h0);
		chk("pattern", 16'h01A5, v);
		cfg(1'h0, 8'h3C, 1'h1);
		chk("locked", 16'h0001, {15'h0000, lko});
		rd_op(1'h0);
		chk("pattern_deny", 16'h0001, {15'h0000, dn});
		chk("pattern_zero", 16'h0000, v);
		rd_op(1'h1);
		chk("sig_open", 16'h0000, {15'h0000, dn});
		chk("sig_data", 16'h5A3C, v);
		cfg(1'h1, 8'hFF, 1'h0);
		chk("cfg_refused", 16'h0000, {15'h0000, hyo});
		wait_act(1'h1, 2'h0);
		t_power(8'h3C);
		chk("lock_kept", 16'h0001, {15'h0000, lko});
		$display("lock done");
	endtask

	initial begin
		// every input settled well before the first rising edge
		rst = 1'h1; wr = 1'h0; hl = 1'h0; lk = 1'h0; ld = 1'h0; rq = 1'h0; sel = 1'h0;
		lvl = 2'h0; pol = 8'h00; d = 8'h00; sig = 16'h5A3C;
		err_count = 0;
		cmp_count = 0;
		repeat (10) @(negedge clk);
		rst = 1'h0;
		chk("reset_state", 16'h0004, {13'h0000, act, hyo, lko});
		cfg(1'h0, 8'hA5, 1'h0);
		t_power(8'hA5);
		t_load_fail;
		t_power(8'hA5);
		t_large;
		t_lock;
		test_done;
	end

	initial begin
		#(5 * 2000);
		err_count++;
		test_done;
	end
endmodule
`default_nettype wire
